// ===== design/lmr_burst_seq.sv
// Column sequencer: walks one burst inside its aligned block
`timescale 1ns/100ps
`default_nettype none
module lmr_burst_seq
  import lmr_pkg::*;
#(
  parameter int COL_W = 10
) (
  input wire logic mclk,
  input wire logic resetn,
  lmr_burst_if.seq bus
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic [3:0] mask_r;          // Offset mask of the aligned block
  logic [3:0] off0_r;          // Start offset inside the block
  logic [COL_W-1:0] base_r;    // Block base column
  logic inter_r;               // Latched ordering mode
  logic [3:0] step_r;          // Step k of the burst
  logic [3:0] left_r;          // Beats still to issue
  logic [3:0] mask_new;        // Mask for a new command
  logic [3:0] off_k;           // Offset for step k
  logic valid_r;
  logic [COL_W-1:0] col_r;
  logic last_r;
  logic read_r;

  // ----------------------------------------------------------------
  // Block selection and ordering
  // ----------------------------------------------------------------
  // Low bits start the burst, the rest choose the block
  assign mask_new = 4'((5'h01 << bus.len_log) - 5'h01);
  // Sequential adds k, interleaved xors k; both wrap in the block
  assign off_k = inter_r ? ((off0_r ^ step_r) & mask_r)
                         : ((off0_r + step_r) & mask_r);

  // Beat generator; a new command cuts a running burst short
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      valid_r <= 1'b0;
      last_r <= 1'b0;
      read_r <= 1'b0;
      col_r <= '0;
      step_r <= 4'h0;
      left_r <= 4'h0;
      mask_r <= 4'h0;
      off0_r <= 4'h0;
      base_r <= '0;
      inter_r <= 1'b0;
    end else if (bus.start) begin
      valid_r <= 1'b1;
      last_r <= 1'b0;
      read_r <= bus.is_read;
      col_r <= bus.start_col;
      step_r <= 4'h1;
      left_r <= 4'(mask_new);
      mask_r <= mask_new;
      off0_r <= bus.start_col[3:0] & mask_new;
      base_r <= {bus.start_col[COL_W-1:4], bus.start_col[3:0] & ~mask_new};
      inter_r <= bus.interleave;
    end else if (left_r != 4'h0) begin
      // Same length for reads and writes
      valid_r <= 1'b1;
      last_r <= (left_r == 4'h1);
      col_r <= {base_r[COL_W-1:4], base_r[3:0] | off_k};
      step_r <= step_r + 4'h1;
      left_r <= left_r - 4'h1;
    end else begin
      valid_r <= 1'b0;
      last_r <= 1'b0;
    end
  end

  assign bus.beat_valid = valid_r;
  assign bus.beat_col = col_r;
  assign bus.beat_last = last_r;
  assign bus.beat_read = read_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_first_beat_col: assert property (bus.start |=>
    (col_r == $past(bus.start_col)) && valid_r)
    else $error("first beat not at start column");
  a_block_stays: assert property (valid_r && !bus.start |=>
    !valid_r || ((col_r & ~{{(COL_W-4){1'b0}}, mask_r}) == base_r))
    else $error("burst left its block");
  a_four_beats: assert property (bus.start && bus.len_log == 3'h2
    ##1 !bus.start [*3] |=> last_r)
    else $error("burst of four did not end on fourth beat");
endmodule : lmr_burst_seq
`default_nettype wire

// ===== design/lmr_mode_regs.sv
// Mode and extended mode registers with burst and read latency control
// Function
// - Base register held until rewrite or power-down.
// - Load command with bank bits 00 latches A0-A13.
// - Rewrite accepted in operation when banks precharged.
// - Burst length from A0-A2: 2,4,8,16.
// - Burst ordering chosen by bit A3.
// - Read latency two or three from A4-A6.
// - Burst wraps inside aligned burst-length column block.
// - Same burst length for reads and writes.
// - Sequential order increments modulo burst length.
// - Interleaved order is start offset xor step.
// - First read data one or two clocks later.
// - Extended register uses bank bits 10, held.
// - Extended fields: partial array, temperature, drive.
// - Refresh fields act only during self refresh.
// - Temperature refresh bits A3-A4 are ignored.
// - Partial array limits self refresh region.
`timescale 1ns/100ps
`default_nettype none
module lmr_mode_regs
  import lmr_pkg::*;
#(
  parameter int COL_W = 10
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [LMR_AW-1:0] addr,
  input wire logic all_banks_idle,
  output logic mode_valid_r,
  output logic mode_reserved_r,
  output logic [4:0] burst_beats_r,
  output logic burst_interleave_r,
  output logic [1:0] read_latency_r,
  output logic ext_valid_r,
  output logic [1:0] drive_strength_r,
  output logic self_refresh_r,
  output logic deep_pd_r,
  output logic [3:0] sr_bank_en_r,
  output logic [1:0] sr_row_msb_zero_r,
  output logic lmr_reject_r,
  output logic rd_first_valid_r,
  output logic beat_valid,
  output logic [COL_W-1:0] beat_col,
  output logic beat_last,
  output logic beat_read
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [3:0] cmd;             // Command lines, chip select first
  logic cmd_ok;                // Commands count only with cke high
  logic lmr_hit;               // Load mode register on the bus
  logic lmr_base;              // Accepted base register load
  logic lmr_ext;               // Accepted extended register load
  logic rw_start;              // Accepted read or write
  logic rd_start;              // Accepted read
  logic [2:0] len_code;        // Length field of the op-code
  logic [2:0] rl_code;         // Latency field of the op-code
  logic len_ok;                // Length code is defined
  logic rl_ok;                 // Latency code is defined
  logic op_ok;                 // Operating mode bits are normal
  lmr_pwr_e pwr_r;             // Power state
  lmr_pwr_e pwr_nxt;
  logic [13:0] mode_reg_r;     // Base register contents
  logic [13:0] ext_reg_r;      // Extended register contents
  logic [2:0] len_log_r;       // log2 of burst length
  logic [1:0] rd_pipe_r;       // Read latency pipeline

  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // Commands are ignored while the clock enable is low
  assign cmd_ok = cke && (pwr_r == PWR_ACTIVE);
  assign lmr_hit = cmd_ok && (cmd == CMD_LMR);
  // Bank bits 00 select base, 10 extended; 01 is not ours
  assign lmr_base = lmr_hit && (ba == BA_BASE) && all_banks_idle;
  assign lmr_ext = lmr_hit && (ba == BA_EXT) && all_banks_idle;
  assign len_code = addr[MR_LEN_LSB +: MR_FLD_W];
  assign rl_code = addr[MR_RL_LSB +: MR_FLD_W];
  // Length codes double per step from 2 to 16
  assign len_ok = (len_code >= LEN_CODE_2) && (len_code <= LEN_CODE_16);
  assign rl_ok = (rl_code == RL_CODE_2) || (rl_code == RL_CODE_3);
  // Anything but all zero in A7-A13 is a reserved mode
  assign op_ok = (addr[MR_OP_LSB +: MR_OP_W] == '0);
  // Bursts need a programmed, non-reserved base register
  assign rw_start = cmd_ok && mode_valid_r &&
                    ((cmd == CMD_READ) || (cmd == CMD_WRITE));
  assign rd_start = rw_start && (cmd == CMD_READ);

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Self refresh and deep power-down are entered with cke low
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_ACTIVE: begin
        if (!cke && !cs_n && (cmd == CMD_REF)) begin
          pwr_nxt = PWR_SELF_REFRESH;
        end else if (!cke && !cs_n && (cmd == CMD_BST)) begin
          pwr_nxt = PWR_DEEP_PD;
        end
      end
      PWR_SELF_REFRESH: begin
        if (cke) begin
          pwr_nxt = PWR_ACTIVE;
        end
      end
      PWR_DEEP_PD: begin
        // Exit leaves the registers empty; reinit is required
        if (cke) begin
          pwr_nxt = PWR_ACTIVE;
        end
      end
      default: begin
        pwr_nxt = PWR_ACTIVE;
      end
    endcase
  end

  // State register and its flags
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pwr_r <= PWR_ACTIVE;
      self_refresh_r <= 1'b0;
      deep_pd_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      self_refresh_r <= (pwr_nxt == PWR_SELF_REFRESH);
      deep_pd_r <= (pwr_nxt == PWR_DEEP_PD);
    end
  end

  // ----------------------------------------------------------------
  // Base mode register
  // ----------------------------------------------------------------
  // Reset clears valid and loads zero contents, length 2, latency 2
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mode_reg_r <= MR_RST;
      mode_valid_r <= 1'b0;
      mode_reserved_r <= 1'b0;
      len_log_r <= 3'h1;
      burst_beats_r <= BEATS_RST;
      burst_interleave_r <= 1'b0;
      read_latency_r <= RL_RST;
    end else if (pwr_nxt == PWR_DEEP_PD) begin
      // Deep power-down loses the contents
      mode_valid_r <= 1'b0;
    end else if (lmr_base) begin
      mode_reg_r <= addr;
      // Reserved codes leave the device unprogrammed
      mode_valid_r <= len_ok && rl_ok && op_ok;
      mode_reserved_r <= !(len_ok && rl_ok && op_ok);
      len_log_r <= len_code;
      burst_beats_r <= 5'(5'h01 << len_code);
      burst_interleave_r <= addr[MR_BT_BIT];
      read_latency_r <= rl_code[1:0];
    end
    // Otherwise every field holds its value
  end

  // ----------------------------------------------------------------
  // Extended mode register
  // ----------------------------------------------------------------
  // Temperature bits are masked; an on-die sensor sets the rate
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ext_reg_r <= MR_RST;
      ext_valid_r <= 1'b0;
      drive_strength_r <= DS_FULL;
    end else if (pwr_nxt == PWR_DEEP_PD) begin
      ext_valid_r <= 1'b0;
    end else if (lmr_ext) begin
      ext_reg_r <= addr & ~14'(14'h0003 << EMR_TCR_LSB);
      ext_valid_r <= 1'b1;
      drive_strength_r <= addr[EMR_DS_LSB +: EMR_DS_W];
    end
  end

  // ----------------------------------------------------------------
  // Self refresh region
  // ----------------------------------------------------------------
  // Outside self refresh the whole array is reported refreshed
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sr_bank_en_r <= BANKS_ALL;
      sr_row_msb_zero_r <= 2'h0;
    end else if ((pwr_nxt != PWR_SELF_REFRESH) || !ext_valid_r) begin
      sr_bank_en_r <= BANKS_ALL;
      sr_row_msb_zero_r <= 2'h0;
    end else begin
      // Region per partial array code; unknown codes keep all
      case (ext_reg_r[EMR_PAR_LSB +: MR_FLD_W])
        PAR_HALF: begin
          sr_bank_en_r <= 4'h3;
          sr_row_msb_zero_r <= 2'h0;
        end
        PAR_QUARTER: begin
          sr_bank_en_r <= 4'h1;
          sr_row_msb_zero_r <= 2'h0;
        end
        PAR_EIGHTH: begin
          sr_bank_en_r <= 4'h1;
          sr_row_msb_zero_r <= 2'h1;
        end
        PAR_SIXTEENTH: begin
          sr_bank_en_r <= 4'h1;
          sr_row_msb_zero_r <= 2'h2;
        end
        default: begin
          sr_bank_en_r <= BANKS_ALL;
          sr_row_msb_zero_r <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Refused loads and read latency
  // ----------------------------------------------------------------
  // A load with banks open is dropped; the flag helps debug
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lmr_reject_r <= 1'b0;
    end else begin
      lmr_reject_r <= lmr_hit && !all_banks_idle &&
                      ((ba == BA_BASE) || (ba == BA_EXT));
    end
  end

  // First data marker one or two edges after the read edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_pipe_r <= 2'h0;
      rd_first_valid_r <= 1'b0;
    end else begin
      rd_pipe_r <= {rd_pipe_r[0], rd_start};
      if (read_latency_r == RL_CODE_3[1:0]) begin
        rd_first_valid_r <= rd_pipe_r[RL3_CYC-1];
      end else begin
        rd_first_valid_r <= rd_pipe_r[RL2_CYC-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  lmr_burst_if #(.COL_W(COL_W)) burst_bus ();

  assign burst_bus.start = rw_start;
  assign burst_bus.is_read = (cmd == CMD_READ);
  assign burst_bus.interleave = burst_interleave_r;
  assign burst_bus.len_log = len_log_r;
  assign burst_bus.start_col = addr[COL_W-1:0];

  lmr_burst_seq #(.COL_W(COL_W)) u_seq (
    .mclk(mclk),
    .resetn(resetn),
    .bus(burst_bus.seq)
  );

  // Beat outputs come from the sequencer flip-flops
  assign beat_valid = burst_bus.beat_valid;
  assign beat_col = burst_bus.beat_col;
  assign beat_last = burst_bus.beat_last;
  assign beat_read = burst_bus.beat_read;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_base_load_fields: assert property (lmr_base && pwr_nxt != PWR_DEEP_PD
    && len_ok |=> (burst_beats_r == 5'(5'h01 << $past(len_code))) &&
    (burst_interleave_r == $past(addr[MR_BT_BIT])))
    else $error("base load fields not taken");
  a_mode_held: assert property (!lmr_base && pwr_nxt != PWR_DEEP_PD
    |=> $stable(mode_reg_r) && $stable(burst_beats_r))
    else $error("base register changed without load");
  a_reject_open: assert property (lmr_hit && !all_banks_idle
    && ba == BA_BASE |=> lmr_reject_r && $stable(mode_reg_r))
    else $error("load with open banks not refused");
  a_reserved_code: assert property (lmr_base && pwr_nxt != PWR_DEEP_PD
    && !rl_ok |=> !mode_valid_r && mode_reserved_r)
    else $error("reserved latency accepted");
  a_latency_two: assert property (rd_start &&
    read_latency_r == RL_CODE_2[1:0] && !lmr_base |-> ##2 rd_first_valid_r)
    else $error("latency two first data late");
  a_latency_three: assert property (rd_start &&
    read_latency_r == RL_CODE_3[1:0] ##1 !lmr_base |-> ##2 rd_first_valid_r)
    else $error("latency three first data late");
  a_drive_taken: assert property (lmr_ext && pwr_nxt != PWR_DEEP_PD
    |=> drive_strength_r == $past(addr[EMR_DS_LSB +: EMR_DS_W]))
    else $error("drive strength not taken");
  a_temp_ignored: assert property (ext_reg_r[EMR_TCR_LSB +: EMR_TCR_W]
    == 2'h0)
    else $error("temperature bits stored");
  a_partial_array_refresh_only_sr: assert property (!self_refresh_r |->
    sr_bank_en_r == BANKS_ALL && sr_row_msb_zero_r == 2'h0)
    else $error("refresh region limited outside self refresh");
  a_dpd_clears: assert property (pwr_nxt == PWR_DEEP_PD |=>
    !mode_valid_r && !ext_valid_r && deep_pd_r)
    else $error("deep power-down kept contents");

  c_len16_inter: cover property (rw_start && len_log_r == LEN_CODE_16
    && burst_interleave_r);
  c_read_rl3: cover property (rd_start && read_latency_r == 2'h3
    ##3 rd_first_valid_r);
  c_sr_region: cover property (self_refresh_r && sr_bank_en_r == 4'h1);
  c_dpd_entry: cover property (deep_pd_r);

endmodule : lmr_mode_regs
`default_nettype wire

// ===== include/lmr_burst_if.sv
// Interface: burst start request and column beat stream between modules
`timescale 1ns/100ps
`default_nettype none
interface lmr_burst_if #(
  parameter int COL_W = 10
);
  logic start;                 // One-cycle burst start
  logic is_read;               // Burst direction
  logic interleave;            // Ordering mode
  logic [2:0] len_log;         // log2 of burst length
  logic [COL_W-1:0] start_col; // Column from the command
  logic beat_valid;            // Column beat valid
  logic [COL_W-1:0] beat_col;  // Column of this beat
  logic beat_last;             // Final beat of the burst
  logic beat_read;             // Direction of this beat

  modport ctl (
    output start, is_read, interleave, len_log, start_col,
    input beat_valid, beat_col, beat_last, beat_read
  );
  modport seq (
    input start, is_read, interleave, len_log, start_col,
    output beat_valid, beat_col, beat_last, beat_read
  );
endinterface : lmr_burst_if
`default_nettype wire

// ===== include/lmr_pkg.sv
// Package: constants and types for the mode register and burst order block
package lmr_pkg;

  // ----------------------------------------------------------------
  // Address bus and field layout
  // ----------------------------------------------------------------
  localparam int LMR_AW = 14;          // A0..A13 carry the op-code
  localparam int MR_FLD_W = 3;         // Width of the length / latency fields
  localparam int MR_LEN_LSB = 0;       // Burst length field A0..A2
  localparam int MR_BT_BIT = 3;        // Burst type bit A3
  localparam int MR_RL_LSB = 4;        // Read latency field A4..A6
  localparam int MR_OP_LSB = 7;        // Operating mode bits A7..A13
  localparam int MR_OP_W = 7;
  localparam int EMR_PAR_LSB = 0;      // Partial array field A0..A2
  localparam int EMR_TCR_LSB = 3;      // Temperature refresh field A3..A4
  localparam int EMR_TCR_W = 2;
  localparam int EMR_DS_LSB = 5;       // Drive strength field A5..A6
  localparam int EMR_DS_W = 2;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_CODE_2 = 3'h1;
  localparam logic [2:0] LEN_CODE_16 = 3'h4;  // Codes 1..4 are log2 of length
  localparam logic [2:0] RL_CODE_2 = 3'h2;
  localparam logic [2:0] RL_CODE_3 = 3'h3;
  localparam logic [1:0] DS_FULL = 2'h0;
  localparam logic [1:0] DS_HALF = 2'h1;
  localparam logic [1:0] DS_QUARTER = 2'h2;
  localparam logic [1:0] DS_THREE_Q = 2'h3;
  localparam logic [2:0] PAR_FULL = 3'h0;
  localparam logic [2:0] PAR_HALF = 3'h1;
  localparam logic [2:0] PAR_QUARTER = 3'h2;
  localparam logic [2:0] PAR_EIGHTH = 3'h5;
  localparam logic [2:0] PAR_SIXTEENTH = 3'h6;

  // ----------------------------------------------------------------
  // Command decode: {cs_n, ras_n, cas_n, we_n} and bank select
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [1:0] BA_BASE = 2'h0;      // {ba1, ba0} = 00
  localparam logic [1:0] BA_EXT = 2'h2;       // {ba1, ba0} = 10

  // ----------------------------------------------------------------
  // Values after reset and cycle counts
  // ----------------------------------------------------------------
  localparam logic [13:0] MR_RST = 14'h0000;
  localparam logic [3:0] BANKS_ALL = 4'hF;
  localparam logic [4:0] BEATS_RST = 5'h02;
  localparam logic [1:0] RL_RST = 2'h2;
  localparam int RL2_CYC = 1;          // Edges after the command, latency 2
  localparam int RL3_CYC = 2;          // Edges after the command, latency 3

  // Power state as seen by the mode logic
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_SELF_REFRESH,
    PWR_DEEP_PD
  } lmr_pwr_e;

endpackage : lmr_pkg

// ===== tb/lmr_ctl_model.sv
// Controller model: drives the command bus of the mode register block
`timescale 1ns/100ps
`default_nettype none
module lmr_ctl_model
  import lmr_pkg::*;
(
  input wire logic mclk,
  output logic cke,
  output logic [3:0] cmd,
  output logic [1:0] ba,
  output logic [LMR_AW-1:0] addr
);
  // ----------------------------------------------------------
  // Idle bus: NOP with clock enabled from time zero
  // ----------------------------------------------------------
  initial begin
    cke = 1'h1;
    cmd = 4'h7;
    ba = 2'h0;
    addr = '0;
  end
  // One command for one cycle, then NOP; lines flip so stale values show
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [LMR_AW-1:0] a, input logic k);
    @(negedge mclk);
    cke = k;
    cmd = c;
    ba = b;
    addr = a;
    @(negedge mclk);
    cmd = 4'h7;
    ba = ~b;
    addr = ~a;
  endtask
  // Load with banks idle, then a spare NOP cycle as settle delay
  task automatic load(input logic [1:0] b, input logic [LMR_AW-1:0] a);
    issue(CMD_LMR, b, a, 1'h1);
    @(negedge mclk);
  endtask
endmodule // lmr_ctl_model
`default_nettype wire

// ===== tb/lmr_mode_register_burst_order_tb_top.sv
// Testbench: mode register loads, burst column order and power states
`timescale 1ns/100ps
`default_nettype none
module lmr_mode_register_burst_order_tb_top
  import lmr_pkg::*;
;
  typedef struct packed {
    logic [13:0] code; // Base register op-code
    logic [9:0] col;   // Start column
    logic rd;          // Read when set
    logic [4:0] n;     // Expected beats
    logic [1:0] lat;   // Expected latency
  } lmr_case_s;
  // ----------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic all_banks_idle = 1'h1; // Bank logic stand-in
  logic cke, mval, mres, ilv, eval, sr, dpd, rej, rdv, bv, blast, brd;
  logic [3:0] cmd, bank_en;
  logic [1:0] ba, rl, ds, row0;
  logic [13:0] addr;
  logic [4:0] beats;
  logic [9:0] bc, m, e;
  int error_cnt = 0;
  int n_tests = 0;
  lmr_case_s rows [7] = '{'{14'h0021, 10'h3FF, 1'h1, 5'h02, 2'h2},
    '{14'h0032, 10'h001, 1'h1, 5'h04, 2'h3},
    '{14'h003A, 10'h001, 1'h1, 5'h04, 2'h3},
    '{14'h002B, 10'h105, 1'h1, 5'h08, 2'h2},
    '{14'h0024, 10'h2BD, 1'h0, 5'h10, 2'h2},
    '{14'h003C, 10'h07D, 1'h1, 5'h10, 2'h3},
    '{14'h0033, 10'h006, 1'h0, 5'h08, 2'h3}};
  logic [13:0] bad [3] = '{14'h00B2, 14'h0042, 14'h0035};
  logic [2:0] pc [4] = '{PAR_FULL, PAR_HALF, PAR_EIGHTH, PAR_SIXTEENTH};
  logic [3:0] pb [4] = '{4'hF, 4'h3, 4'h1, 4'h1};
  always #5 mclk = ~mclk;
  lmr_ctl_model ctl (.mclk(mclk), .cke(cke), .cmd(cmd), .ba(ba),
    .addr(addr));
  lmr_mode_regs dut (.mclk(mclk), .resetn(resetn), .cke(cke),
    .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
    .ba(ba), .addr(addr), .all_banks_idle(all_banks_idle),
    .mode_valid_r(mval), .mode_reserved_r(mres), .burst_beats_r(beats),
    .burst_interleave_r(ilv), .read_latency_r(rl), .ext_valid_r(eval),
    .drive_strength_r(ds), .self_refresh_r(sr), .deep_pd_r(dpd),
    .sr_bank_en_r(bank_en), .sr_row_msb_zero_r(row0),
    .lmr_reject_r(rej), .rd_first_valid_r(rdv), .beat_valid(bv),
    .beat_col(bc), .beat_last(blast), .beat_read(brd));
  // ----------------------------------------------------------
  // Compare and closing report
  // ----------------------------------------------------------
  task automatic chk(input logic [9:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard: a stuck run counts as a failure
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (3) @(negedge mclk);
    resetn = 1'h1;
    chk(beats, 2, "reset length");
    chk(rl, 2, "reset latency");
    chk(mval, 0, "reset valid");
    chk(bank_en, 4'hF, "reset banks");
    // Table: load, then walk one burst and its first-data pulse
    for (int i = 0; i < 7; i++) begin
      ctl.load(BA_BASE, rows[i].code);
      chk(mval, 1, "valid");
      chk(beats, rows[i].n, "length");
      chk(ilv, rows[i].code[3], "type");
      chk(rl, rows[i].lat, "latency");
      ctl.issue(rows[i].rd ? CMD_READ : CMD_WRITE, 2'h0,
        {4'h0, rows[i].col}, 1'h1);
      m = 10'(rows[i].n - 1);
      for (int k = 0; k < rows[i].n; k++) begin
        e = rows[i].code[3] ? (rows[i].col ^ 10'(k)) : (rows[i].col + 10'(k));
        chk(bv, 1, "beat");
        chk(bc, (rows[i].col & ~m) | (e & m), "column");
        chk(blast, k == rows[i].n - 1, "last");
        chk(brd, rows[i].rd, "direction");
        chk(rdv, rows[i].rd && k == rows[i].lat - 1, "first");
        @(negedge mclk);
      end
      chk(bv, 0, "end");
    end
    // Busy banks: load refused, fields kept; bank pattern 01 ignored
    all_banks_idle = 1'h0;
    ctl.issue(CMD_LMR, BA_BASE, 14'h0021, 1'h1);
    chk(rej, 1, "refuse");
    all_banks_idle = 1'h1;
    ctl.load(2'h1, 14'h0021);
    chk(beats, 8, "kept");
    // Reserved codes: flagged and bursts refused
    for (int i = 0; i < 3; i++) begin
      ctl.load(BA_BASE, bad[i]);
      chk(mval, 0, "reserved");
      chk(mres, 1, "reserved flag");
      ctl.issue(CMD_READ, 2'h0, 14'h0000, 1'h1);
      chk(bv, 0, "refused burst");
    end
    // Extended register: drive codes, ignored refresh bits, regions
    for (int i = 0; i < 4; i++) begin
      ctl.load(BA_EXT, {7'h00, 2'(i), 2'(i), pc[i]});
      chk(eval, 1, "ext valid");
      chk(ds, i, "drive");
      chk(bank_en, 4'hF, "awake");
      ctl.issue(CMD_REF, 2'h0, 14'h0000, 1'h0);
      @(negedge mclk);
      chk(sr, 1, "self refresh");
      chk(bank_en, pb[i], "banks");
      chk(row0, i < 2 ? 0 : i - 1, "rows");
      ctl.issue(4'h7, 2'h0, 14'h0000, 1'h1);
      @(negedge mclk);
      chk(bank_en, 4'hF, "woken");
    end
    // Deep power-down loses both registers
    ctl.load(BA_BASE, 14'h0032);
    ctl.issue(CMD_BST, 2'h0, 14'h0000, 1'h0);
    chk(dpd, 1, "deep");
    chk(mval, 0, "lost base");
    chk(eval, 0, "lost ext");
    ctl.issue(4'h7, 2'h0, 14'h0000, 1'h1);
    ctl.issue(CMD_READ, 2'h0, 14'h0000, 1'h1);
    chk(bv, 0, "no burst");
    end_sim();
  end
endmodule // lmr_mode_register_burst_order_tb_top
`default_nettype wire
